/* bench/omc_board.sv */
`timescale 1ns/1ps
// board straps and pin driver standing in for the system side
module omc_board
(
   input wire logic clk,
   input wire logic powering,
   input wire logic hw_sel_req,
   input wire logic en_req,
   input wire logic [3:0] range_req,
   input wire logic reset_req_n,
   output logic control_source_select_pin,
   output logic reset_pin_n,
   output logic output_drive_enable,
   output logic range_decode_bit3,
   output logic range_decode_bit2,
   output logic range_decode_bit1,
   output logic range_decode_bit0
);
   logic [3:0] range_q;

   // strap level: low picks software, high hardware
   assign control_source_select_pin = hw_sel_req;
   // no reset in hardware mode, so the pin is tied high there
   assign reset_pin_n = hw_sel_req ? 1'b1 : reset_req_n;
   assign {range_decode_bit3, range_decode_bit2, range_decode_bit1, range_decode_bit0} = range_q;

   // enable dropped first, range moved a cycle later, so no glitch into a wrong range
   always_ff @(posedge clk)
   begin
      if (powering)
      begin
         output_drive_enable <= 1'b0;
         range_q <= range_req;
      end
      else if (range_q != range_req)
      begin
         if (output_drive_enable)
            output_drive_enable <= 1'b0;
         else
            range_q <= range_req;
      end
      else
         output_drive_enable <= en_req;
   end
endmodule

/* bench/test_omc_top.sv */
`timescale 1ns/1ps
// self-checking bench: random and corner control traffic in both modes
module test_omc_top;
   logic clk, reset, hw_sel_req, en_req, reset_req_n, en;
   logic [3:0] range_req;
   logic sel_pin, rst_n_pin, en_pin, rb3, rb2, rb1, rb0;
   logic [omc_pkg::ADDR_W-1:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, cur_oe, volt_oe, hardware_mode;
   logic [31:0] avs_writedata, avs_readdata, rdata, rnd;
   logic [3:0] avs_byteenable, active_range;
   int n_errors, comparisons, cycles, seed;

   omc_board omc_board_i (.clk(clk), .powering(reset), .hw_sel_req(hw_sel_req), .en_req(en_req),
      .range_req(range_req), .reset_req_n(reset_req_n), .control_source_select_pin(sel_pin),
      .reset_pin_n(rst_n_pin), .output_drive_enable(en_pin), .range_decode_bit3(rb3),
      .range_decode_bit2(rb2), .range_decode_bit1(rb1), .range_decode_bit0(rb0));

   omc_top omc_top_i (.clk(clk), .reset(reset), .control_source_select_pin(sel_pin),
      .reset_pin_n(rst_n_pin), .output_drive_enable(en_pin), .range_decode_bit3(rb3),
      .range_decode_bit2(rb2), .range_decode_bit1(rb1), .range_decode_bit0(rb0),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .current_output_pin_oe(cur_oe),
      .voltage_output_pin_oe(volt_oe), .active_range(active_range), .hardware_mode(hardware_mode));

   // free-running clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // expected {voltage, current} drive for an enable and a range code
   function automatic logic [1:0] exp_oe(input logic e, input logic [3:0] code);
      logic is_cur, is_volt;
      is_cur = code <= omc_pkg::RANGE_CUR_0_24MA;
      is_volt = code >= omc_pkg::RANGE_VOLT_0_5V && code <= omc_pkg::RANGE_VOLT_PM10V;
      return {e & is_volt, e & is_cur};
   endfunction

   // expected status word from mode, {voltage, current} drive, range code and reset pin
   function automatic logic [31:0] exp_stat(input logic hw, input logic [1:0] oe, input logic [3:0] code,
      input logic pin_rst);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[omc_pkg::STAT_HW_MODE_BIT] = hw;
      w[omc_pkg::STAT_CUR_DRIVE_BIT] = oe[0];
      w[omc_pkg::STAT_VOLT_DRIVE_BIT] = oe[1];
      w[omc_pkg::STAT_RANGE_OK_BIT] = code <= omc_pkg::RANGE_VOLT_PM10V;
      w[omc_pkg::STAT_RANGE_LSB +: 4] = code;
      w[omc_pkg::STAT_PIN_RESET_BIT] = pin_rst;
      w[omc_pkg::STAT_MODE_KNOWN_BIT] = 1'b1;
      return w;
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data, input logic [3:0] be);
      @(posedge clk);
      avs_address <= addr;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= data;
      avs_byteenable <= be;
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   // let the settings reach the pins, then compare the drive state
   task automatic expect_out(input int wait_n, input logic e, input logic [3:0] code);
      logic [1:0] oe;
      repeat (wait_n) @(posedge clk);
      #1;
      oe = exp_oe(e, code);
      check("current oe", {31'h0, cur_oe}, {31'h0, oe[0]});
      check("voltage oe", {31'h0, volt_oe}, {31'h0, oe[1]});
      if (e)
         check("range", {28'h0, active_range}, {28'h0, code});
   endtask

   task automatic do_reset(input logic hw);
      @(posedge clk);
      hw_sel_req <= hw;
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("mode", {31'h0, hardware_mode}, {31'h0, hw});
   endtask

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         $display("timeout after %0d cycles", cycles);
         final_report();
      end
   end

   initial
   begin
      seed = 32'h0edb;
      {reset, hw_sel_req, en_req, range_req, reset_req_n} = {1'b1, 1'b0, 1'b0, 4'h0, 1'b1};
      {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
      do_reset(1'b0);
      expect_out(0, 1'b0, 4'h0);
      bus(1'b0, omc_pkg::CTRL_OFFSET, 32'h0, 4'hF);
      check("ctrl after power-up", rdata, 32'h0);
      // every range code, enable drawn at random
      for (int i = 0; i < 16; i++)
      begin
         rnd = $random(seed);
         en = rnd[0] | (i == 3) | (i == 6);
         bus(1'b1, omc_pkg::CTRL_OFFSET, {27'h0, en, 4'(i)}, 4'hF);
         expect_out(3, en, 4'(i));
         bus(1'b0, omc_pkg::CTRL_OFFSET, 32'h0, 4'hF);
         check("ctrl readback", rdata, {27'h0, en, 4'(i)});
      end
      // lane 0 off, status and unmapped writes change nothing
      bus(1'b1, omc_pkg::CTRL_OFFSET, 32'h16, 4'hF);
      bus(1'b1, omc_pkg::CTRL_OFFSET, 32'h03, 4'hE);
      bus(1'b1, omc_pkg::STATUS_OFFSET, 32'h0, 4'hF);
      bus(1'b1, 4'h8, 32'h0, 4'hF);
      expect_out(3, 1'b1, 4'h6);
      bus(1'b0, 4'h8, 32'h0, 4'hF);
      check("unmapped read", rdata, 32'h0);
      // reset bit written together with enable and range
      bus(1'b1, omc_pkg::CTRL_OFFSET, 32'h33, 4'hF);
      expect_out(3, 1'b0, 4'h3);
      bus(1'b0, omc_pkg::CTRL_OFFSET, 32'h0, 4'hF);
      check("ctrl after reset bit", rdata, 32'h0);
      // reset pin held low blocks writes until released
      bus(1'b1, omc_pkg::CTRL_OFFSET, 32'h13, 4'hF);
      expect_out(3, 1'b1, 4'h3);
      @(posedge clk);
      reset_req_n <= 1'b0;
      expect_out(3, 1'b0, 4'h3);
      bus(1'b1, omc_pkg::CTRL_OFFSET, 32'h17, 4'hF);
      expect_out(8, 1'b0, 4'h7);
      bus(1'b0, omc_pkg::STATUS_OFFSET, 32'h0, 4'hF);
      check("status pin reset", rdata, exp_stat(1'b0, 2'b00, omc_pkg::CTRL_RANGE_RST, 1'b1));
      @(posedge clk);
      reset_req_n <= 1'b1;
      expect_out(3, 1'b0, 4'h7);
      bus(1'b1, omc_pkg::CTRL_OFFSET, 32'h12, 4'hF);
      expect_out(3, 1'b1, 4'h2);
      bus(1'b0, omc_pkg::STATUS_OFFSET, 32'h0, 4'hF);
      check("status software", rdata, exp_stat(1'b0, exp_oe(1'b1, 4'h2), 4'h2, 1'b0));
      // hardware mode: pins rule, control writes do not
      do_reset(1'b1);
      for (int i = 0; i < 16; i++)
      begin
         rnd = $random(seed);
         @(posedge clk);
         range_req <= 4'(i);
         en_req <= rnd[0] | (i == 2) | (i == 8);
         expect_out(7, rnd[0] | (i == 2) | (i == 8), 4'(i));
      end
      bus(1'b1, omc_pkg::CTRL_OFFSET, 32'h25, 4'hF);
      expect_out(3, en_req, 4'hF);
      // a driving voltage range, so an honoured reset write would show as a dropped output
      @(posedge clk);
      range_req <= omc_pkg::RANGE_VOLT_0_5V;
      en_req <= 1'b1;
      expect_out(7, 1'b1, omc_pkg::RANGE_VOLT_0_5V);
      bus(1'b1, omc_pkg::CTRL_OFFSET, 32'h25, 4'hF);
      expect_out(3, 1'b1, omc_pkg::RANGE_VOLT_0_5V);
      bus(1'b0, omc_pkg::STATUS_OFFSET, 32'h0, 4'hF);
      check("status hardware", rdata, exp_stat(1'b1, exp_oe(1'b1, omc_pkg::RANGE_VOLT_0_5V),
         omc_pkg::RANGE_VOLT_0_5V, 1'b0));
      final_report();
   end
endmodule

/* src/omc_avs.sv */
`timescale 1ns/1ps
// avalon-mm slave front end with one wait cycle per access
module omc_avs
(
   input wire logic clk,
   input wire logic reset,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] rd_word,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic reg_write
);

   // wait one cycle, then release for exactly one edge
   always_ff @(posedge clk)
   begin
      if (reset)
         avs_waitrequest <= 1'b1;
      else if ((avs_read || avs_write) && avs_waitrequest)
         avs_waitrequest <= 1'b0;
      else
         avs_waitrequest <= 1'b1;
   end

   // read data captured as the release is issued, stands through the taking edge
   always_ff @(posedge clk)
   begin
      if (reset)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read && avs_waitrequest)
         avs_readdata <= rd_word;
   end

   // write takes effect only at the edge where waitrequest is seen low
   assign reg_write = avs_write && !avs_waitrequest;

endmodule

/* src/omc_pkg.sv */
package omc_pkg;

   // register map, byte addresses on a 32-bit word bus
   localparam int ADDR_W = 4;
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;

   // control register fields
   localparam int CTRL_RANGE_LSB = 0;
   localparam int CTRL_RANGE_W = 4;
   localparam int CTRL_ENABLE_BIT = 4;
   localparam int CTRL_RESET_BIT = 5;
   localparam logic [3:0] CTRL_RANGE_RST = 4'h0;
   localparam logic CTRL_ENABLE_RST = 1'b0;
   localparam logic CTRL_RESET_RST = 1'b0;

   // status register fields
   localparam int STAT_HW_MODE_BIT = 0;
   localparam int STAT_CUR_DRIVE_BIT = 1;
   localparam int STAT_VOLT_DRIVE_BIT = 2;
   localparam int STAT_RANGE_OK_BIT = 3;
   localparam int STAT_RANGE_LSB = 4;
   localparam int STAT_PIN_RESET_BIT = 8;
   localparam int STAT_MODE_KNOWN_BIT = 9;

   // output range codes, shared by the range field and the decode pins
   localparam logic [3:0] RANGE_CUR_PM20MA = 4'h0;
   localparam logic [3:0] RANGE_CUR_PM24MA = 4'h1;
   localparam logic [3:0] RANGE_CUR_0_20MA = 4'h2;
   localparam logic [3:0] RANGE_CUR_4_20MA = 4'h3;
   localparam logic [3:0] RANGE_CUR_0_24MA = 4'h4;
   localparam logic [3:0] RANGE_VOLT_0_5V = 4'h5;
   localparam logic [3:0] RANGE_VOLT_0_10V = 4'h6;
   localparam logic [3:0] RANGE_VOLT_PM5V = 4'h7;
   localparam logic [3:0] RANGE_VOLT_PM10V = 4'h8;

   // control source, picked once after power-up
   typedef enum logic [1:0] {
      OMC_POWERUP = 2'b00,
      OMC_SOFTWARE = 2'b01,
      OMC_HARDWARE = 2'b10
   } omc_mode_e;

endpackage

/* src/omc_range_decode.sv */
`timescale 1ns/1ps
// maps a range code onto the output that it drives
module omc_range_decode
(
   input wire logic [3:0] range_code,
   output logic is_current,
   output logic is_voltage
);

   // codes outside the table drive nothing rather than guess an output
   always_comb
   begin
      is_current = 1'b0;
      is_voltage = 1'b0;
      case (range_code)
         omc_pkg::RANGE_CUR_PM20MA,
         omc_pkg::RANGE_CUR_PM24MA,
         omc_pkg::RANGE_CUR_0_20MA,
         omc_pkg::RANGE_CUR_4_20MA,
         omc_pkg::RANGE_CUR_0_24MA: is_current = 1'b1;
         omc_pkg::RANGE_VOLT_0_5V,
         omc_pkg::RANGE_VOLT_0_10V,
         omc_pkg::RANGE_VOLT_PM5V,
         omc_pkg::RANGE_VOLT_PM10V: is_voltage = 1'b1;
         default: is_current = 1'b0;
      endcase
   end

endmodule

/* src/omc_top.sv */
// Function
// - mode-select pin level after power-up picks software or hardware control.
// - never enable current and voltage outputs at the same time.
// - range code selects one of five current or four voltage ranges.
// - software mode powers up with enable bit zero, both outputs off.
// - disabled outputs are both placed in high impedance.
// - software mode follows the enable bit of the control register.
// - hardware mode powers up with range pins and enable pin settings.
// - hardware mode decodes range from the four range-decode pins.
// - hardware mode follows enable pin, tri-stating both outputs when disabled.
// - software mode resets on reset pin low or reset bit write.
// - reset disables and tri-states outputs until a new enabling write.
// - reset pin is level sensitive; reset holds while pin is low.
// - reset bit returns to zero by itself after the reset.
// - hardware mode has no reset; board ties the reset pin high.
`timescale 1ns/1ps
module omc_top
(
   input wire logic clk,
   input wire logic reset,
   input wire logic control_source_select_pin,
   input wire logic reset_pin_n,
   input wire logic output_drive_enable,
   input wire logic range_decode_bit3,
   input wire logic range_decode_bit2,
   input wire logic range_decode_bit1,
   input wire logic range_decode_bit0,
   input wire logic [omc_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic current_output_pin_oe,
   output logic voltage_output_pin_oe,
   output logic [3:0] active_range,
   output logic hardware_mode
);

   omc_pkg::omc_mode_e mode;
   logic [3:0] ctrl_range;
   logic ctrl_enable;
   logic ctrl_reset_bit;
   logic reg_write;
   logic ctrl_write;
   logic [31:0] rd_word;
   logic [3:0] pin_range;
   logic [3:0] eff_range;
   logic eff_enable;
   logic is_current;
   logic is_voltage;
   logic pin_reset_active;

   // bus front end
   omc_avs u_avs
   (
      .clk(clk),
      .reset(reset),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .rd_word(rd_word),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .reg_write(reg_write)
   );

   // only the low byte holds control fields; other lanes change nothing
   assign ctrl_write = reg_write && (avs_address == omc_pkg::CTRL_OFFSET) && avs_byteenable[0];

   // control source is latched once, in the first cycle after reset
   always_ff @(posedge clk)
   begin
      if (reset)
         mode <= omc_pkg::OMC_POWERUP;
      else
      begin
         case (mode)
            omc_pkg::OMC_POWERUP: mode <= control_source_select_pin ? omc_pkg::OMC_HARDWARE
                                                                    : omc_pkg::OMC_SOFTWARE;
            omc_pkg::OMC_SOFTWARE: mode <= omc_pkg::OMC_SOFTWARE;
            omc_pkg::OMC_HARDWARE: mode <= omc_pkg::OMC_HARDWARE;
            default: mode <= omc_pkg::OMC_POWERUP;
         endcase
      end
   end

   // the reset pin counts only under software control
   assign pin_reset_active = (mode == omc_pkg::OMC_SOFTWARE) && !reset_pin_n;

   // control register; a reset bit write wins over the enable and range it carries
   always_ff @(posedge clk)
   begin
      if (reset || mode != omc_pkg::OMC_SOFTWARE)
      begin
         ctrl_range <= omc_pkg::CTRL_RANGE_RST;
         ctrl_enable <= omc_pkg::CTRL_ENABLE_RST;
         ctrl_reset_bit <= omc_pkg::CTRL_RESET_RST;
      end
      else if (pin_reset_active)
      begin
         // held cleared as long as the pin stays low; writes are lost meanwhile
         ctrl_range <= omc_pkg::CTRL_RANGE_RST;
         ctrl_enable <= omc_pkg::CTRL_ENABLE_RST;
         ctrl_reset_bit <= omc_pkg::CTRL_RESET_RST;
      end
      else if (ctrl_write && avs_writedata[omc_pkg::CTRL_RESET_BIT])
      begin
         ctrl_range <= omc_pkg::CTRL_RANGE_RST;
         ctrl_enable <= omc_pkg::CTRL_ENABLE_RST;
         ctrl_reset_bit <= 1'b1;
      end
      else if (ctrl_write)
      begin
         // enable and range arrive together in one write
         ctrl_range <= avs_writedata[omc_pkg::CTRL_RANGE_LSB +: omc_pkg::CTRL_RANGE_W];
         ctrl_enable <= avs_writedata[omc_pkg::CTRL_ENABLE_BIT];
         ctrl_reset_bit <= 1'b0;
      end
      else if (ctrl_reset_bit)
         ctrl_reset_bit <= 1'b0;
   end

   // range pins replace the control register range field in hardware control
   assign pin_range = {range_decode_bit3, range_decode_bit2, range_decode_bit1, range_decode_bit0};

   // effective settings from the active control source
   always_comb
   begin
      case (mode)
         omc_pkg::OMC_SOFTWARE:
         begin
            eff_range = ctrl_range;
            eff_enable = ctrl_enable && !ctrl_reset_bit && !pin_reset_active;
         end
         omc_pkg::OMC_HARDWARE:
         begin
            // pins are followed live; no reset path exists here
            eff_range = pin_range;
            eff_enable = output_drive_enable;
         end
         default:
         begin
            eff_range = omc_pkg::CTRL_RANGE_RST;
            eff_enable = 1'b0;
         end
      endcase
   end

   omc_range_decode u_decode
   (
      .range_code(eff_range),
      .is_current(is_current),
      .is_voltage(is_voltage)
   );

   // the decode is one-hot by construction, so one pin at most drives
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         current_output_pin_oe <= 1'b0;
         voltage_output_pin_oe <= 1'b0;
         active_range <= omc_pkg::CTRL_RANGE_RST;
      end
      else
      begin
         current_output_pin_oe <= eff_enable && is_current;
         voltage_output_pin_oe <= eff_enable && is_voltage;
         active_range <= eff_range;
      end
   end

   // mode flag for the board side
   always_ff @(posedge clk)
   begin
      if (reset)
         hardware_mode <= 1'b0;
      else
         hardware_mode <= (mode == omc_pkg::OMC_HARDWARE);
   end

   // read mux; unmapped addresses read zero
   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (avs_address)
         omc_pkg::CTRL_OFFSET:
         begin
            rd_word[omc_pkg::CTRL_RANGE_LSB +: omc_pkg::CTRL_RANGE_W] = ctrl_range;
            rd_word[omc_pkg::CTRL_ENABLE_BIT] = ctrl_enable;
            rd_word[omc_pkg::CTRL_RESET_BIT] = ctrl_reset_bit;
         end
         omc_pkg::STATUS_OFFSET:
         begin
            rd_word[omc_pkg::STAT_HW_MODE_BIT] = (mode == omc_pkg::OMC_HARDWARE);
            rd_word[omc_pkg::STAT_CUR_DRIVE_BIT] = current_output_pin_oe;
            rd_word[omc_pkg::STAT_VOLT_DRIVE_BIT] = voltage_output_pin_oe;
            rd_word[omc_pkg::STAT_RANGE_OK_BIT] = is_current || is_voltage;
            rd_word[omc_pkg::STAT_RANGE_LSB +: 4] = eff_range;
            rd_word[omc_pkg::STAT_PIN_RESET_BIT] = pin_reset_active;
            rd_word[omc_pkg::STAT_MODE_KNOWN_BIT] = (mode != omc_pkg::OMC_POWERUP);
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   one_output_only_a: assert property (!(current_output_pin_oe && voltage_output_pin_oe))
      else $error("current and voltage outputs enabled together");

   mode_pick_a: assert property (mode == omc_pkg::OMC_POWERUP |=>
      (mode == (control_source_select_pin ? omc_pkg::OMC_HARDWARE : omc_pkg::OMC_SOFTWARE)))
      else $error("control source not taken from select pin");

   sw_powerup_off_a: assert property ((mode == omc_pkg::OMC_POWERUP) ##1 (mode == omc_pkg::OMC_SOFTWARE)
      |-> !ctrl_enable ##1 (!current_output_pin_oe && !voltage_output_pin_oe))
      else $error("software mode did not power up disabled");

   sw_enable_a: assert property ((mode == omc_pkg::OMC_SOFTWARE) && ctrl_enable && !ctrl_reset_bit
      && !pin_reset_active && is_current |=> current_output_pin_oe && !voltage_output_pin_oe)
      else $error("enable bit not followed");

   hw_follow_a: assert property ((mode == omc_pkg::OMC_HARDWARE) && !output_drive_enable
      |=> !current_output_pin_oe && !voltage_output_pin_oe)
      else $error("hardware disable not tri-stating");

   hw_range_a: assert property ((mode == omc_pkg::OMC_HARDWARE) && output_drive_enable
      |=> active_range == $past(pin_range) && voltage_output_pin_oe == $past(is_voltage))
      else $error("hardware range not taken from pins");

   pin_reset_a: assert property (pin_reset_active |=> !ctrl_enable && !current_output_pin_oe
      && !voltage_output_pin_oe)
      else $error("reset pin low but outputs active");

   // the register is held cleared outside software control, so only software writes count here
   reset_cmd_a: assert property ((mode == omc_pkg::OMC_SOFTWARE) && ctrl_write
      && avs_writedata[omc_pkg::CTRL_RESET_BIT] && !pin_reset_active
      |=> ctrl_reset_bit && !ctrl_enable ##1 !current_output_pin_oe && !voltage_output_pin_oe)
      else $error("reset bit write did not disable outputs");

   reset_clear_a: assert property (ctrl_reset_bit && !ctrl_write |=> !ctrl_reset_bit)
      else $error("reset bit did not clear itself");

   hw_no_reset_a: assert property ((mode == omc_pkg::OMC_HARDWARE)
      && (!reset_pin_n || (ctrl_write && avs_writedata[omc_pkg::CTRL_RESET_BIT]))
      && output_drive_enable && is_voltage |=> voltage_output_pin_oe)
      else $error("reset acted in hardware mode");

   field_hold_a: assert property ((mode == omc_pkg::OMC_SOFTWARE) && !ctrl_write && !pin_reset_active
      |=> $stable(ctrl_range) && $stable(ctrl_enable))
      else $error("control fields changed without a write");

   // output side: decode, tri-state and the source of the range
   disabled_off_a: assert property (!eff_enable |=> !current_output_pin_oe && !voltage_output_pin_oe)
      else $error("disabled output still driving");

   range_to_pin_a: assert property (eff_enable |=> current_output_pin_oe == $past(is_current)
      && voltage_output_pin_oe == $past(is_voltage))
      else $error("range code drove the wrong output");

   sw_disable_a: assert property ((mode == omc_pkg::OMC_SOFTWARE) && !ctrl_enable
      |=> !current_output_pin_oe && !voltage_output_pin_oe)
      else $error("outputs driving with enable bit clear");

   sw_volt_enable_a: assert property ((mode == omc_pkg::OMC_SOFTWARE) && ctrl_enable && !ctrl_reset_bit
      && !pin_reset_active && is_voltage |=> voltage_output_pin_oe && !current_output_pin_oe)
      else $error("enable bit not followed on voltage range");

   sw_range_src_a: assert property ((mode == omc_pkg::OMC_SOFTWARE) |=> active_range == $past(ctrl_range))
      else $error("software range not taken from the control register");

   hw_powerup_a: assert property ((mode == omc_pkg::OMC_POWERUP) ##1 (mode == omc_pkg::OMC_HARDWARE)
      |-> ##1 (active_range == $past(pin_range)))
      else $error("hardware power-up range not taken from pins");

   mode_locked_a: assert property (mode != omc_pkg::OMC_POWERUP |=> $stable(mode))
      else $error("control source changed after power-up");

   reset_fields_a: assert property (ctrl_reset_bit |-> !ctrl_enable
      && (ctrl_range == omc_pkg::CTRL_RANGE_RST))
      else $error("reset bit set with fields not cleared");

   pin_held_a: assert property (pin_reset_active ##1 pin_reset_active |-> !ctrl_enable
      && !current_output_pin_oe && !voltage_output_pin_oe)
      else $error("outputs active while reset pin held low");

   // a stale enable here would leak out if software control were ever re-entered without reset
   hw_ctrl_idle_a: assert property ((mode == omc_pkg::OMC_HARDWARE) |-> !ctrl_enable && !ctrl_reset_bit)
      else $error("control register active in hardware mode");

   // scenarios the bench is meant to reach
   cur_drive_c: cover property (current_output_pin_oe);
   volt_drive_c: cover property (voltage_output_pin_oe);
   soft_reset_c: cover property (ctrl_reset_bit ##1 !ctrl_reset_bit);
   pin_reset_c: cover property (pin_reset_active [*3]);
   hw_drive_c: cover property (hardware_mode && voltage_output_pin_oe);

endmodule
